/* File: verilog/bsl_pkg.sv */
// bsl_pkg: constants, register map and carrier types of the backup status sideband block
package bsl_pkg;
    // clock and time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    // blink figures in milliseconds
    localparam int FAST_ON_MS = 100;
    localparam int FAST_OFF_MS = 200;
    localparam int SLOW_PERIOD_MS = 15000;
    localparam int SLOW_ON_MS = 100;
    localparam int BLINK_W = 14;
    // smbus quarter bit time, 100 kHz bus
    localparam int SMB_QUARTER_NS = 2500;
    localparam int SMB_QUARTER_CYC = SMB_QUARTER_NS / CLK_PERIOD_NS;
    localparam logic [3:0] SMB_ACK_BIT = 4'h8;
    // register offsets
    localparam logic [7:0] OFS_USER_IND = 8'h11;
    localparam logic [7:0] OFS_CTRL = 8'h12;
    localparam logic [7:0] OFS_STATUS = 8'h13;
    localparam logic [7:0] OFS_INT_STAT = 8'h14;
    localparam logic [7:0] OFS_INT_MASK = 8'h15;
    localparam logic [7:0] OFS_SMB_ADDR = 8'h16;
    localparam logic [7:0] OFS_SMB_TX = 8'h17;
    localparam logic [7:0] OFS_SMB_RX = 8'h18;
    localparam logic [7:0] OFS_SMB_GO = 8'h19;
    // values
    localparam logic [7:0] USER_IND_ON = 8'h01;
    localparam logic [7:0] USER_IND_OFF = 8'h00;
    localparam logic [7:0] USER_IND_RESET = 8'h00;
    localparam logic [7:0] ZERO8 = 8'h00;
    // control bits
    localparam int CTRL_DISCHARGE = 0;
    localparam int CTRL_PFAIL_SAVE = 1;
    // status bits
    localparam int ST_PRESENT = 0;
    localparam int ST_PFAIL = 1;
    localparam int ST_SMB_BUSY = 2;
    localparam int ST_SMB_NACK = 3;
    // event bits
    localparam int EV_PFAIL = 0;
    localparam int EV_PRESENT = 1;
    localparam int EV_SMB_DONE = 2;
    localparam int EV_W = 3;
    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bsl_reg_req_t;
    // smbus transfer request
    typedef struct packed {
        logic [6:0] slave;
        logic readNotWrite;
        logic [7:0] txData;
    } bsl_smb_req_t;
endpackage

/* File: verilog/bsl_smb_master.sv */
// bsl_smb_master: one-byte smbus master toward the energy module
`timescale 1ns/1ps
module bsl_smb_master #(
    parameter int QUARTER_CYC = bsl_pkg::SMB_QUARTER_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // request side
    input wire logic go,
    input wire bsl_pkg::bsl_smb_req_t req,
    output logic busy,
    output logic done,
    output logic [7:0] rxData,
    output logic nack,
    // bus pins
    output logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe
);
    typedef enum logic [1:0] {S_IDLE, S_START, S_BIT, S_STOP} bsl_smb_state_t;
    localparam int QW = $clog2(QUARTER_CYC + 1);
    localparam logic [QW-1:0] QLAST = QW'(QUARTER_CYC - 1);

    bsl_smb_state_t state_q;
    logic [QW-1:0] qCnt_q; // quarter bit divider
    logic [1:0] phase_q;
    logic [3:0] bitIdx_q;
    logic byteIdx_q; // 0 address byte, 1 data byte
    logic rw_q;
    logic [7:0] shift_q, tx_q;
    logic sclQ, sdaLow_q;
    logic sdaMeta_q, sdaSync_q; // pin synchroniser

    wire qTick = (state_q != S_IDLE) && (qCnt_q == QLAST);
    wire ackBit = (bitIdx_q == bsl_pkg::SMB_ACK_BIT);
    // the slave drives the data byte of a read, and the master nacks it
    wire release_w = ackBit || (byteIdx_q && rw_q);
    wire ackChecked = !(byteIdx_q && rw_q);

    assign busy = (state_q != S_IDLE);
    assign scl = sclQ;
    assign sdaOut = 1'b0; // open drain: only ever pulls low
    assign sdaOe = sdaLow_q;

    // two flops before the data line is looked at
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sdaMeta_q <= 1'b1;
            sdaSync_q <= 1'b1;
        end else begin
            sdaMeta_q <= sdaIn;
            sdaSync_q <= sdaMeta_q;
        end
    end

    // quarter divider runs only during a transfer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) qCnt_q <= '0;
        else if (!busy || qTick) qCnt_q <= '0;
        else qCnt_q <= qCnt_q + 1'b1;
    end

    // bit sequencer: start, address, data, stop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= S_IDLE;
            phase_q <= '0;
            bitIdx_q <= '0;
            byteIdx_q <= 1'b0;
            rw_q <= 1'b0;
            shift_q <= '0;
            tx_q <= '0;
            sclQ <= 1'b1;
            sdaLow_q <= 1'b0;
            rxData <= '0;
            nack <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (state_q == S_IDLE) begin
                if (go) begin
                    state_q <= S_START;
                    phase_q <= '0;
                    bitIdx_q <= '0;
                    byteIdx_q <= 1'b0;
                    rw_q <= req.readNotWrite;
                    shift_q <= {req.slave, req.readNotWrite};
                    tx_q <= req.txData;
                    nack <= 1'b0;
                end
            end else if (qTick) begin
                phase_q <= phase_q + 1'b1;
                unique case (state_q)
                    S_START: begin
                        // data falls while the clock is high
                        if (phase_q == 2'd0) sdaLow_q <= 1'b1;
                        else if (phase_q == 2'd1) begin
                            sclQ <= 1'b0;
                            state_q <= S_BIT;
                            phase_q <= '0;
                        end
                    end
                    S_BIT: begin
                        unique case (phase_q)
                            2'd0: sdaLow_q <= !release_w && !shift_q[7];
                            2'd1: sclQ <= 1'b1;
                            2'd2: begin
                                if (!ackBit) shift_q <= {shift_q[6:0], sdaSync_q};
                                else if (ackChecked && sdaSync_q) nack <= 1'b1;
                            end
                            2'd3: begin
                                sclQ <= 1'b0;
                                if (!ackBit) bitIdx_q <= bitIdx_q + 1'b1;
                                else if (!byteIdx_q && !nack) begin
                                    byteIdx_q <= 1'b1;
                                    bitIdx_q <= '0;
                                    shift_q <= rw_q ? 8'hff : tx_q;
                                end else begin
                                    if (rw_q && byteIdx_q) rxData <= shift_q;
                                    state_q <= S_STOP;
                                end
                            end
                        endcase
                    end
                    S_STOP: begin
                        // data rises while the clock is high
                        unique case (phase_q)
                            2'd0: sdaLow_q <= 1'b1;
                            2'd1: sclQ <= 1'b1;
                            2'd2: sdaLow_q <= 1'b0;
                            2'd3: begin
                                state_q <= S_IDLE;
                                done <= 1'b1;
                            end
                        endcase
                    end
                    default: state_q <= S_IDLE;
                endcase
            end
        end
    end

    // clock and data stay released while idle
    a_smb_idle_bus: assert property (@(posedge clk) disable iff (!nrst)
        !busy |-> (scl && !sdaOe))
        else $error("smbus lines not released while idle");
endmodule

/* File: verilog/bsl_sideband.sv */
// bsl_sideband: indicators, energy module sideband pins and register port
// Contract
// - green indicator lit while controller powered
// - save or restore: blue 100ms on, 200ms off
// - operational: slow blue blink every 15 seconds
// - amber follows writes of 0x01 and 0x00
// - reads return stored register, not driver
// - discharge command pulls present line low
// - low present line means module connected
// - power-fail assertion may start backup save
// - device is smbus master toward module
`timescale 1ns/1ps
module bsl_sideband #(
    parameter int CYC_PER_MS = bsl_pkg::CYC_PER_MS,
    parameter int SMB_QUARTER_CYC = bsl_pkg::SMB_QUARTER_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire bsl_pkg::bsl_reg_req_t regReq,
    output logic [7:0] regRdata,
    // controller state, same clock
    input wire logic saveActive,
    input wire logic restoreActive,
    input wire logic fwLoaded,
    // indicators, save request and interrupt
    output logic powerIndicator,
    output logic activityIndicator,
    output logic userIndicator,
    output logic powerLossBackupSave,
    output logic irq,
    // energy module pins
    output logic capSmbClock,
    input wire logic capSmbDataIn,
    output logic capSmbDataOut,
    output logic capSmbDataOe,
    input wire logic presentIn,
    output logic presentOut,
    output logic presentOe,
    input wire logic powerFailN
);
    localparam int MSW = $clog2(CYC_PER_MS + 1);
    localparam logic [MSW-1:0] MS_LAST = MSW'(CYC_PER_MS - 1);
    localparam logic [bsl_pkg::BLINK_W-1:0] FAST_ON =
        bsl_pkg::BLINK_W'(bsl_pkg::FAST_ON_MS);
    localparam logic [bsl_pkg::BLINK_W-1:0] FAST_PER =
        bsl_pkg::BLINK_W'(bsl_pkg::FAST_ON_MS + bsl_pkg::FAST_OFF_MS);
    localparam logic [bsl_pkg::BLINK_W-1:0] SLOW_ON =
        bsl_pkg::BLINK_W'(bsl_pkg::SLOW_ON_MS);
    localparam logic [bsl_pkg::BLINK_W-1:0] SLOW_PER =
        bsl_pkg::BLINK_W'(bsl_pkg::SLOW_PERIOD_MS);

    // registers written by software
    logic [7:0] userCtl_q; // amber indicator storage
    logic [7:0] ctrl_q; // discharge and save enable
    logic [7:0] smbAddr_q, smbTx_q;
    logic [bsl_pkg::EV_W-1:0] intStat_q, intMask_q;
    // pin synchronisers
    logic pfMeta_q, pfSync_q, pfPrev_q;
    logic prMeta_q, prSync_q;
    logic present_q; // latest connected reading
    // blink timing
    logic [MSW-1:0] msCnt_q;
    logic [bsl_pkg::BLINK_W-1:0] blinkMs_q;
    logic busyPrev_q;
    // smbus master results
    logic smbBusy, smbDone, smbNack;
    logic [7:0] smbRx;

    // address decode
    wire wrUser = regReq.wr && (regReq.addr == bsl_pkg::OFS_USER_IND);
    wire wrCtrl = regReq.wr && (regReq.addr == bsl_pkg::OFS_CTRL);
    wire wrIntStat = regReq.wr && (regReq.addr == bsl_pkg::OFS_INT_STAT);
    wire wrIntMask = regReq.wr && (regReq.addr == bsl_pkg::OFS_INT_MASK);
    wire wrSmbAddr = regReq.wr && (regReq.addr == bsl_pkg::OFS_SMB_ADDR);
    wire wrSmbTx = regReq.wr && (regReq.addr == bsl_pkg::OFS_SMB_TX);
    wire wrSmbGo = regReq.wr && (regReq.addr == bsl_pkg::OFS_SMB_GO);
    // a go while a transfer runs is dropped
    wire smbGo = wrSmbGo && regReq.wdata[0] && !smbBusy;

    // control decode
    wire discharge = ctrl_q[bsl_pkg::CTRL_DISCHARGE];
    wire pfailSaveEn = ctrl_q[bsl_pkg::CTRL_PFAIL_SAVE];
    wire pfailFall = pfPrev_q && !pfSync_q;
    wire presentNow = !prSync_q;
    wire presentChg = !discharge && (presentNow != present_q);
    wire msTick = (msCnt_q == MS_LAST);
    wire opBusy = saveActive || restoreActive;
    wire [bsl_pkg::BLINK_W-1:0] blinkPer = opBusy ? FAST_PER : SLOW_PER;
    wire [bsl_pkg::BLINK_W-1:0] blinkOn = opBusy ? FAST_ON : SLOW_ON;
    wire blinkWrap = msTick && (blinkMs_q == blinkPer - 1'b1);

    // event sources for the sticky status bits
    wire [bsl_pkg::EV_W-1:0] events = {smbDone, presentChg, pfailFall};
    wire [7:0] statusWord = {4'h0, smbNack, smbBusy, !pfSync_q, present_q};

    // read mux
    logic [7:0] rdMux;
    always_comb begin
        unique case (regReq.addr)
            bsl_pkg::OFS_USER_IND: rdMux = userCtl_q;
            bsl_pkg::OFS_CTRL: rdMux = ctrl_q;
            bsl_pkg::OFS_STATUS: rdMux = statusWord;
            bsl_pkg::OFS_INT_STAT: rdMux = {5'h00, intStat_q};
            bsl_pkg::OFS_INT_MASK: rdMux = {5'h00, intMask_q};
            bsl_pkg::OFS_SMB_ADDR: rdMux = smbAddr_q;
            bsl_pkg::OFS_SMB_TX: rdMux = smbTx_q;
            bsl_pkg::OFS_SMB_RX: rdMux = smbRx;
            default: rdMux = bsl_pkg::ZERO8; // unmapped reads zero
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) regRdata <= bsl_pkg::ZERO8;
        else regRdata <= regReq.rd ? rdMux : bsl_pkg::ZERO8;
    end

    // software registers; amber starts dark
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            userCtl_q <= bsl_pkg::USER_IND_RESET;
            ctrl_q <= bsl_pkg::ZERO8;
            smbAddr_q <= bsl_pkg::ZERO8;
            smbTx_q <= bsl_pkg::ZERO8;
            intMask_q <= '0;
        end else begin
            if (wrUser) userCtl_q <= regReq.wdata;
            if (wrCtrl) ctrl_q <= regReq.wdata;
            if (wrSmbAddr) smbAddr_q <= regReq.wdata;
            if (wrSmbTx) smbTx_q <= regReq.wdata;
            if (wrIntMask) intMask_q <= regReq.wdata[bsl_pkg::EV_W-1:0];
        end
    end

    // sticky events, write one to clear; a new event beats the clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) intStat_q <= '0;
        else if (wrIntStat) intStat_q <= (intStat_q & ~regReq.wdata[bsl_pkg::EV_W-1:0]) | events;
        else intStat_q <= intStat_q | events;
    end

    assign irq = |(intStat_q & intMask_q);

    // power-fail and present pins pass two flops first
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pfMeta_q <= 1'b1;
            pfSync_q <= 1'b1;
            pfPrev_q <= 1'b1;
            prMeta_q <= 1'b1;
            prSync_q <= 1'b1;
        end else begin
            pfMeta_q <= powerFailN;
            pfSync_q <= pfMeta_q;
            pfPrev_q <= pfSync_q;
            prMeta_q <= presentIn;
            prSync_q <= prMeta_q;
        end
    end

    // presence is frozen while we pull the line low ourselves
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) present_q <= 1'b0;
        else if (!discharge) present_q <= presentNow;
    end

    // open-drain discharge command
    assign presentOut = 1'b0;
    assign presentOe = discharge;

    // power-fail assertion raises a one-cycle save request when enabled
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) powerLossBackupSave <= 1'b0;
        else powerLossBackupSave <= pfailFall && pfailSaveEn;
    end

    // millisecond enable divider
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) msCnt_q <= '0;
        else if (msTick) msCnt_q <= '0;
        else msCnt_q <= msCnt_q + 1'b1;
    end

    // blink phase restarts whenever the mode flips, so a save shows at once
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blinkMs_q <= '0;
            busyPrev_q <= 1'b0;
        end else begin
            busyPrev_q <= opBusy;
            if (opBusy != busyPrev_q) blinkMs_q <= '0;
            else if (blinkWrap) blinkMs_q <= '0;
            else if (msTick) blinkMs_q <= blinkMs_q + 1'b1;
        end
    end

    // indicator outputs come from flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            powerIndicator <= 1'b0;
            activityIndicator <= 1'b0;
            userIndicator <= 1'b0;
        end else begin
            powerIndicator <= 1'b1;
            // dark when neither busy nor loaded
            activityIndicator <= (opBusy || fwLoaded) && (blinkMs_q < blinkOn);
            userIndicator <= userCtl_q[0];
        end
    end

    // smbus master toward the energy module
    bsl_smb_master #(.QUARTER_CYC(SMB_QUARTER_CYC)) bsl_smb_master_i (
        .clk(clk),
        .nrst(nrst),
        .go(smbGo),
        .req({smbAddr_q[6:0], smbAddr_q[7], smbTx_q}),
        .busy(smbBusy),
        .done(smbDone),
        .rxData(smbRx),
        .nack(smbNack),
        .scl(capSmbClock),
        .sdaIn(capSmbDataIn),
        .sdaOut(capSmbDataOut),
        .sdaOe(capSmbDataOe)
    );

    // steps of the save request
    sequence s_pfail_edge;
        pfailFall && pfailSaveEn;
    endsequence
    sequence s_save_pulse;
        ##1 powerLossBackupSave ##1 !powerLossBackupSave;
    endsequence

    a_power_led_lit: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) |-> powerIndicator)
        else $error("power indicator dark while running");
    a_fast_blink_on: assert property (@(posedge clk) disable iff (!nrst)
        (opBusy && $stable(opBusy) && blinkMs_q < FAST_ON) |=> activityIndicator)
        else $error("blue not lit in fast on phase");
    a_fast_blink_wrap: assert property (@(posedge clk) disable iff (!nrst)
        (opBusy && $stable(opBusy) && msTick && blinkMs_q == FAST_PER - 1'b1)
        |=> blinkMs_q == '0)
        else $error("fast blink period wrong");
    a_slow_blink_off: assert property (@(posedge clk) disable iff (!nrst)
        (!opBusy && $stable(opBusy) && blinkMs_q >= SLOW_ON) |=> !activityIndicator)
        else $error("blue lit outside slow blink");
    a_user_write_on: assert property (@(posedge clk) disable iff (!nrst)
        (wrUser && regReq.wdata == bsl_pkg::USER_IND_ON) |=> ##1 userIndicator)
        else $error("amber not on after write");
    a_user_write_off: assert property (@(posedge clk) disable iff (!nrst)
        (wrUser && regReq.wdata == bsl_pkg::USER_IND_OFF) |=> ##1 !userIndicator)
        else $error("amber not off after write");
    a_user_read_back: assert property (@(posedge clk) disable iff (!nrst)
        (regReq.rd && regReq.addr == bsl_pkg::OFS_USER_IND) |=> regRdata == $past(userCtl_q))
        else $error("user register read mismatch");
    a_discharge_pull: assert property (@(posedge clk) disable iff (!nrst)
        wrCtrl && regReq.wdata[bsl_pkg::CTRL_DISCHARGE] |=> presentOe && !presentOut)
        else $error("discharge not driven low");
    a_present_sense: assert property (@(posedge clk) disable iff (!nrst)
        (!discharge && $stable(prSync_q)) |=> present_q == !$past(prSync_q))
        else $error("presence reading inverted");
    a_pfail_save_req: assert property (@(posedge clk) disable iff (!nrst)
        s_pfail_edge |-> s_save_pulse)
        else $error("power fail did not request save");
endmodule

/* File: verif/bsl_cap_model.sv */
// bsl_cap_model: behavioural energy module on the far side of the sideband pins
`timescale 1ns/1ps
module bsl_cap_model #(
    parameter logic [6:0] SLAVE = 7'h2c, // bus address, arbitrary
    parameter logic [7:0] RD_BYTE = 8'ha5 // byte returned on reads
) (
    // smbus side
    input wire logic smbClock,
    input wire logic smbData,
    output logic smbDataPull,
    output logic [7:0] gotByte,
    // sideband pins
    input wire logic connected,
    output logic presentPull,
    input wire logic pfail,
    output logic powerFailN
);
    // a fitted module sinks the shared present line
    assign presentPull = connected;
    // low while input power is under threshold
    assign powerFailN = !pfail;
    // slave: data only moves while the clock is low, so start detection is safe
    initial begin
        logic [7:0] sh;
        logic hit;
        smbDataPull = 1'b0;
        gotByte = 8'h00;
        sh = 8'h00;
        forever begin
            @(negedge smbData iff smbClock === 1'b1);
            for (int i = 0; i < 8; i++) begin
                @(posedge smbClock);
                sh = {sh[6:0], smbData};
            end
            hit = (sh[7:1] == SLAVE);
            @(negedge smbClock);
            smbDataPull = hit;
            @(negedge smbClock);
            smbDataPull = 1'b0;
            if (hit && sh[0]) begin
                // read: shift our byte out msb first, then let the master answer
                for (int i = 7; i >= 0; i--) begin
                    smbDataPull = !RD_BYTE[i];
                    @(negedge smbClock);
                end
                smbDataPull = 1'b0;
            end else if (hit) begin
                for (int i = 0; i < 8; i++) begin
                    @(posedge smbClock);
                    sh = {sh[6:0], smbData};
                end
                gotByte = sh;
                @(negedge smbClock);
                smbDataPull = 1'b1;
                @(negedge smbClock);
                smbDataPull = 1'b0;
            end
        end
    end
endmodule

/* File: verif/bsl_sideband_tb.sv */
// bsl_sideband_tb: self-checking bench of the sideband block
`timescale 1ns/1ps
module bsl_sideband_tb;
    localparam logic [6:0] SLV = 7'h2c;
    localparam logic [7:0] RDB = 8'ha5;
    logic clk, nrst, saveActive, restoreActive, fwLoaded, connected, pfail;
    bsl_pkg::bsl_reg_req_t regReq;
    logic [7:0] regRdata, gotByte, rnd;
    logic powerIndicator, activityIndicator, userIndicator, powerLossBackupSave, irq;
    logic capSmbClock, capSmbDataOut, capSmbDataOe, presentOut, presentOe, powerFailN;
    logic smbPull, presPull;
    logic rdLast = 1'b0;
    // both lines have pull-ups: high unless some party sinks them
    wire sdaLine = !((capSmbDataOe && !capSmbDataOut) || smbPull);
    wire presLine = !((presentOe && !presentOut) || presPull);
    int n_fail = 0;
    int checks = 0;
    int saves = 0;
    logic [7:0] expQ[$]; // expected read data, oldest first

    bsl_sideband #(.CYC_PER_MS(10), .SMB_QUARTER_CYC(4)) bsl_sideband_i (.clk(clk), .nrst(nrst),
        .regReq(regReq), .regRdata(regRdata), .saveActive(saveActive),
        .restoreActive(restoreActive), .fwLoaded(fwLoaded), .powerIndicator(powerIndicator),
        .activityIndicator(activityIndicator), .userIndicator(userIndicator),
        .powerLossBackupSave(powerLossBackupSave), .irq(irq), .capSmbClock(capSmbClock),
        .capSmbDataIn(sdaLine), .capSmbDataOut(capSmbDataOut), .capSmbDataOe(capSmbDataOe),
        .presentIn(presLine), .presentOut(presentOut), .presentOe(presentOe),
        .powerFailN(powerFailN));
    bsl_cap_model #(.SLAVE(SLV), .RD_BYTE(RDB)) bsl_cap_model_i (.smbClock(capSmbClock),
        .smbData(sdaLine), .smbDataPull(smbPull), .gotByte(gotByte), .connected(connected),
        .presentPull(presPull), .pfail(pfail), .powerFailN(powerFailN));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // read data stands only in the cycle after the strobe, so compare there
    always @(posedge clk) begin
        rdLast <= regReq.rd;
        if (rdLast) begin
            if (expQ.size() == 0) check("unexpected read", 1, 0);
            else check("regRdata", regRdata, expQ.pop_front());
        end
        if (powerLossBackupSave === 1'b1) saves <= saves + 1;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    // bus cycles: one strobe cycle, then one idle edge so strobes never re-assert in a step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        regReq.wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        regReq.rd <= 1'b0;
        @(posedge clk);
    endtask
    // one smbus byte transfer, finished when the done event raises irq
    task automatic smbXfer(input logic [7:0] a, input logic [7:0] d);
        int i;
        i = 0;
        wr(bsl_pkg::OFS_SMB_ADDR, a);
        wr(bsl_pkg::OFS_SMB_TX, d);
        wr(bsl_pkg::OFS_SMB_GO, 8'h01);
        while (irq !== 1'b1 && i < 1000) begin
            @(posedge clk);
            i++;
        end
        if (irq !== 1'b1) begin
            check("smbus done timeout", 0, 1);
            test_done();
        end
        wr(bsl_pkg::OFS_INT_STAT, 8'h04);
        check("irq cleared", irq, 0);
    endtask
    // count lit cycles of the blue indicator over a window
    task automatic litCount(input int len, output int n);
        n = 0;
        repeat (len) begin
            @(posedge clk);
            if (activityIndicator === 1'b1) n++;
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        int n;
        nrst = 1'b0;
        regReq = '0;
        saveActive = 1'b0;
        restoreActive = 1'b0;
        fwLoaded = 1'b0;
        connected = 1'b0;
        pfail = 1'b0;
        void'($urandom(32'ha7d6));
        repeat (8) @(posedge clk);
        check("green in reset", powerIndicator, 0);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        check("green lit", powerIndicator, 1);
        check("amber at reset", userIndicator, 0);
        rd(bsl_pkg::OFS_USER_IND, bsl_pkg::USER_IND_RESET);
        $display("test reset done");
        // amber follows bit0, a read gives back the whole stored byte
        wr(bsl_pkg::OFS_USER_IND, bsl_pkg::USER_IND_ON);
        @(posedge clk);
        check("amber on", userIndicator, 1);
        rd(bsl_pkg::OFS_USER_IND, bsl_pkg::USER_IND_ON);
        rnd = 8'($urandom());
        wr(bsl_pkg::OFS_USER_IND, rnd);
        @(posedge clk);
        check("amber bit0", userIndicator, rnd[0]);
        rd(bsl_pkg::OFS_USER_IND, rnd);
        wr(bsl_pkg::OFS_USER_IND, bsl_pkg::USER_IND_OFF);
        @(posedge clk);
        check("amber off", userIndicator, 0);
        rd(8'h40, 8'h00);
        $display("test amber done");
        // presence: event raises irq through the mask, write-one clears it
        wr(bsl_pkg::OFS_INT_MASK, 8'h02);
        connected <= 1'b1;
        repeat (6) @(posedge clk);
        check("presence irq", irq, 1);
        rd(bsl_pkg::OFS_STATUS, 8'h01);
        rd(bsl_pkg::OFS_INT_STAT, 8'h02);
        wr(bsl_pkg::OFS_INT_STAT, 8'h02);
        check("presence irq clear", irq, 0);
        wr(bsl_pkg::OFS_CTRL, 8'h01);
        connected <= 1'b0;
        repeat (6) @(posedge clk);
        check("discharge pull", presLine, 0);
        rd(bsl_pkg::OFS_STATUS, 8'h01);
        wr(bsl_pkg::OFS_CTRL, 8'h00);
        repeat (6) @(posedge clk);
        check("discharge released", presentOe, 0);
        rd(bsl_pkg::OFS_STATUS, 8'h00);
        wr(bsl_pkg::OFS_INT_STAT, 8'hff);
        $display("test present done");
        // power fail: save request only when enabled
        pfail <= 1'b1;
        repeat (8) @(posedge clk);
        check("no save when disabled", saves, 0);
        rd(bsl_pkg::OFS_STATUS, 8'h02);
        rd(bsl_pkg::OFS_INT_STAT, 8'h01);
        pfail <= 1'b0;
        wr(bsl_pkg::OFS_CTRL, 8'h02);
        wr(bsl_pkg::OFS_INT_STAT, 8'hff);
        pfail <= 1'b1;
        repeat (8) @(posedge clk);
        check("one save pulse", saves, 1);
        pfail <= 1'b0;
        wr(bsl_pkg::OFS_CTRL, 8'h00);
        wr(bsl_pkg::OFS_INT_STAT, 8'hff);
        $display("test power fail done");
        // smbus write, read and an unanswered address
        wr(bsl_pkg::OFS_INT_MASK, 8'h04);
        rnd = 8'($urandom());
        smbXfer({1'b0, SLV}, rnd);
        check("byte at module", gotByte, rnd);
        rd(bsl_pkg::OFS_STATUS, 8'h00);
        smbXfer({1'b1, SLV}, 8'h00);
        rd(bsl_pkg::OFS_SMB_RX, RDB);
        smbXfer({1'b0, SLV ^ 7'h01}, 8'h00);
        rd(bsl_pkg::OFS_STATUS, 8'h08);
        $display("test smbus done");
        // blue: dark when idle, fast blink 1000 of 3000 cycles, slow afterwards
        litCount(2000, n);
        check("blue dark", n, 0);
        saveActive <= 1'b1;
        litCount(3000, n);
        litCount(6000, n);
        check("fast blink save", n, 2000);
        saveActive <= 1'b0;
        restoreActive <= 1'b1;
        litCount(6000, n);
        check("fast blink restore", n, 2000);
        restoreActive <= 1'b0;
        fwLoaded <= 1'b1;
        litCount(6000, n);
        check("slow blink", n >= 990 && n <= 1010, 1);
        $display("test blink done");
        test_done();
    end
endmodule
